//--- design/adc_pin_pkg.sv
package adc_pin_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] PERIOD_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] RX_OFS     = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CH_LSB        = 0;
  localparam int ST_DATA_READY_N       = 0;
  localparam int ST_UNREAD     = 1;
  localparam int ST_HELD       = 2;
  localparam int ST_STBY       = 3;
  localparam int ST_BUF        = 4;
  localparam int ST_BITCNT_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  CTRL_RST   = 3'h0;
  localparam logic [15:0] PERIOD_RST = 16'h07D0;
  localparam logic [23:0] RESULT_RST = 24'h00_0000;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  // Master clock cycles that data ready is raised before an update
  localparam logic [15:0] DATA_READY_N_HIGH_MCLK = 16'h01F4;
  // Last bit index of one 24-bit output word
  localparam logic [4:0]  WORD_LAST      = 5'h17;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    CH_P1_COM,
    CH_P2_COM,
    CH_P3_COM,
    CH_P4_COM,
    CH_D1_2,
    CH_D3_4,
    CH_D5_COM
  } chan_e;

  typedef enum logic {FLT_HELD, FLT_RUN} flt_state_e;

  typedef struct packed
  {
    logic       buffer_en;
    logic       shutdown;
    logic       modulator_reset;
    logic       filter_reset;
    logic [5:0] pos_sel;
    logic [5:0] neg_sel;
  } analog_ctrl_s;

  typedef struct packed
  {
    logic mclk;
    logic sclk;
    logic din;
    logic cs_n;
    logic idle_sel;
    logic filter_sync_n;
    logic reset_n;
    logic standby_n;
    logic buffer_sel;
  } pins_s;

  // Pin idle levels, so the synchroniser leaves reset looking inactive
  localparam pins_s PINS_RST = '{mclk:          1'b0,
                                 sclk:          1'b0,
                                 din:           1'b0,
                                 cs_n:          1'b1,
                                 idle_sel:      1'b0,
                                 filter_sync_n: 1'b1,
                                 reset_n:       1'b1,
                                 standby_n:     1'b1,
                                 buffer_sel:    1'b0};

endpackage

//--- design/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff
#(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // Two flops; the first is read by the second only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= RESET_VAL;
      q      <= RESET_VAL;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

//--- design/edge_find.sv
`timescale 1ns/1ps
module edge_find
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic level,
  input  wire logic idle_level,
  input  wire logic enable,
  output logic      active
);

  logic prev_q;

  // Previous sample of the already synchronised level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prev_q <= 1'b0;
    else
      prev_q <= level;
  end

  // First edge leaves the idle level: rising for idle low, else falling
  assign active = enable && (prev_q == idle_level) && (level != idle_level);

endmodule

//--- design/adc_pin_control_logic.sv
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// - Serial clock continuous or bursts, state kept
// - Master clock output is inverted input
// - Idle select low: first edge rising
// - Idle select high: first edge falling
// - Filter sync low holds filter and modulator
// - Filter sync spares serial port and data ready
// - Reset pin returns port, filter and data ready to power-on state; registers keep their values except RX, which clears
// - Standby low shuts down digital and analog
// - Buffer select low bypasses input buffer
// - Channels: pairs 1/2, 3/4, pseudo 1-5
// - Data ready low on update, high after read
// - Unread data: ready high 500 cycles before update
// - Chip select gates port; tied low for three-wire
module adc_pin_control_logic
  import adc_pin_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        mclk_in,
  output logic             mclk_out,
  input  wire logic        sclk,
  input  wire logic        din,
  input  wire logic        cs_n,
  output logic             dout,
  output logic             dout_oe,
  output logic             data_ready_n,
  input  wire logic        clock_idle_level_sel,
  input  wire logic        filter_sync_n,
  input  wire logic        reset_pin_n,
  input  wire logic        standby_n,
  input  wire logic        buffer_sel,
  output analog_ctrl_s     analog_ctrl
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pins_s pins_raw;
  pins_s pins;

  assign pins_raw = '{mclk:          mclk_in,
                      sclk:          sclk,
                      din:           din,
                      cs_n:          cs_n,
                      idle_sel:      clock_idle_level_sel,
                      filter_sync_n: filter_sync_n,
                      reset_n:       reset_pin_n,
                      standby_n:     standby_n,
                      buffer_sel:    buffer_sel};

  // Active-low pins wake up high, so no false reset or standby pulse
  sync_2ff #(.WIDTH($bits(pins_s)), .RESET_VAL(PINS_RST)) u_pin_sync
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (pins_raw),
    .q       (pins)
  );

  // Straight inversion; a clock must not pick up sync latency
  assign mclk_out = ~mclk_in;

  // ----------------------------------------------------------------
  // Control levels
  // ----------------------------------------------------------------
  logic dev_rst;
  logic standby;
  logic filter_hold;
  logic port_en;

  assign dev_rst     = ~pins.reset_n;
  assign standby     = ~pins.standby_n;
  assign filter_hold = ~pins.filter_sync_n | standby | dev_rst;
  // Chip select gates the port; held low it is open unless in standby or reset
  assign port_en     = ~pins.cs_n & ~standby & ~dev_rst;

  // ----------------------------------------------------------------
  // Edge finders
  // ----------------------------------------------------------------
  logic sclk_act;
  logic mclk_tick;

  // Active edge per idle level; no reset between bursts
  edge_find u_sclk_edge
  (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .level      (pins.sclk),
    .idle_level (pins.idle_sel),
    .enable     (port_en),
    .active     (sclk_act)
  );

  // Master clock rising edges serve as the conversion enable
  edge_find u_mclk_edge
  (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .level      (pins.mclk),
    .idle_level (1'b0),
    .enable     (~standby),
    .active     (mclk_tick)
  );

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic        wr_q;
  logic [7:0]  wr_addr_q;
  logic [2:0]  ctrl_q;
  logic [15:0] period_q;
  logic [23:0] result_q;
  logic [31:0] hrdata_q;
  logic        addr_take;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  assign addr_take = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;  // Zero wait states
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // Address phase latch for writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q      <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_q      <= addr_take & hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Data phase writes; unmapped addresses are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q   <= CTRL_RST;
      period_q <= PERIOD_RST;
      result_q <= RESULT_RST;
    end
    else if (wr_q)
    begin
      if (wr_addr_q == CTRL_OFS)
        ctrl_q <= hwdata[CH_LSB +: 3];
      else if (wr_addr_q == PERIOD_OFS)
        period_q <= hwdata[15:0];
      else if (wr_addr_q == RESULT_OFS)
        result_q <= hwdata[23:0];
    end
  end

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  logic [4:0]  bit_cnt_q;
  logic [23:0] tx_q;
  logic [7:0]  rx_q;
  logic [7:0]  rx_byte_q;
  logic        word_done;
  logic        update;

  assign word_done = sclk_act && (bit_cnt_q == WORD_LAST);

  // Count survives gaps in the clock and chip select rises
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bit_cnt_q <= 5'h00;
    else if (dev_rst || standby)
      bit_cnt_q <= 5'h00;
    else if (word_done)
      bit_cnt_q <= 5'h00;
    else if (sclk_act)
      bit_cnt_q <= bit_cnt_q + 5'h01;
  end

  // Word only reloads between reads, so a read is never torn
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_q <= RESULT_RST;
    else if (dev_rst)
      tx_q <= RESULT_RST;
    else if (update && bit_cnt_q == 5'h00)
      tx_q <= result_q;
    else if (sclk_act)
      tx_q <= {tx_q[22:0], 1'b0};
  end

  // Input shift and last whole byte received
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_q      <= 8'h00;
      rx_byte_q <= 8'h00;
    end
    else if (dev_rst)
    begin
      rx_q      <= 8'h00;
      rx_byte_q <= 8'h00;
    end
    else if (sclk_act)
    begin
      rx_q <= {rx_q[6:0], pins.din};
      if (bit_cnt_q[2:0] == 3'h7)
        rx_byte_q <= {rx_q[6:0], pins.din};
    end
  end

  // Output driven only while selected
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end
    else
    begin
      dout    <= tx_q[23];
      dout_oe <= port_en;
    end
  end

  // ----------------------------------------------------------------
  // Filter sequencer
  // ----------------------------------------------------------------
  flt_state_e  flt_q;
  logic [15:0] conv_cnt_q;
  logic        conv_last;
  logic        warn;

  assign conv_last = conv_cnt_q == (period_q - 16'h0001);
  assign update    = (flt_q == FLT_RUN) && mclk_tick && conv_last;
  // Period below the warning span simply never warns
  assign warn      = (flt_q == FLT_RUN) && mclk_tick &&
                     (conv_cnt_q == period_q - DATA_READY_N_HIGH_MCLK - 16'h0001);

  // Held state clears the count; release restarts at zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flt_q      <= FLT_HELD;
      conv_cnt_q <= 16'h0000;
    end
    else
    begin
      case (flt_q)
        FLT_HELD:
        begin
          conv_cnt_q <= 16'h0000;
          if (!filter_hold)
            flt_q <= FLT_RUN;
        end
        FLT_RUN:
        begin
          if (filter_hold)
          begin
            flt_q      <= FLT_HELD;
            conv_cnt_q <= 16'h0000;
          end
          else if (mclk_tick)
            conv_cnt_q <= conv_last ? 16'h0000 : conv_cnt_q + 16'h0001;
        end
        default:
          flt_q <= FLT_HELD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data ready
  // ----------------------------------------------------------------
  logic data_ready_n_n_q;
  logic unread_q;

  assign data_ready_n = data_ready_n_n_q;

  // Filter sync is absent here on purpose: a low flag stays low
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_ready_n_n_q <= 1'b1;
      unread_q <= 1'b0;
    end
    else if (dev_rst)
    begin
      data_ready_n_n_q <= 1'b1;
      unread_q <= 1'b0;
    end
    else if (update)
    begin
      data_ready_n_n_q <= 1'b0;
      unread_q <= 1'b1;
    end
    else if (word_done)
    begin
      data_ready_n_n_q <= 1'b1;
      unread_q <= 1'b0;
    end
    else if (warn && unread_q)
      data_ready_n_n_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Analog control
  // ----------------------------------------------------------------
  function automatic logic [11:0] chan_decode(input logic [2:0] code);
    logic [11:0] sel;
    sel = 12'h000;
    case (chan_e'(code))
      CH_P1_COM: sel = {6'b000001, 6'b100000};
      CH_P2_COM: sel = {6'b000010, 6'b100000};
      CH_P3_COM: sel = {6'b000100, 6'b100000};
      CH_P4_COM: sel = {6'b001000, 6'b100000};
      CH_D1_2:   sel = {6'b000001, 6'b000010};
      CH_D3_4:   sel = {6'b000100, 6'b001000};
      CH_D5_COM: sel = {6'b010000, 6'b100000};
      default:   sel = 12'h000;
    endcase
    return sel;
  endfunction

  logic [11:0] chan_sel;

  assign chan_sel = chan_decode(ctrl_q);

  // Registered so the analog side never sees a decode glitch
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      analog_ctrl <= '{buffer_en:       1'b0,
                       shutdown:        1'b0,
                       modulator_reset: 1'b1,
                       filter_reset:    1'b1,
                       pos_sel:         6'h00,
                       neg_sel:         6'h00};
    else
    begin
      analog_ctrl.buffer_en       <= pins.buffer_sel;
      analog_ctrl.shutdown        <= standby;
      analog_ctrl.modulator_reset <= filter_hold;
      analog_ctrl.filter_reset    <= filter_hold;
      analog_ctrl.pos_sel         <= chan_sel[11:6];
      analog_ctrl.neg_sel         <= chan_sel[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign status_word = {19'h0_0000, bit_cnt_q, 3'h0,
                        pins.buffer_sel, standby, filter_hold,
                        unread_q, data_ready_n_n_q};

  assign rd_mux = (haddr[7:0] == CTRL_OFS)   ? {29'h0000_0000, ctrl_q} :
                  (haddr[7:0] == PERIOD_OFS) ? {16'h0000, period_q} :
                  (haddr[7:0] == RESULT_OFS) ? {8'h00, result_q} :
                  (haddr[7:0] == STATUS_OFS) ? status_word :
                  (haddr[7:0] == RX_OFS)     ? {24'h00_0000, rx_byte_q} :
                  32'h0000_0000;

  // Read data captured at the address phase, shown in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h0000_0000;
    else if (addr_take && !hwrite)
      hrdata_q <= rd_mux;
  end

endmodule

//--- test/adc_pin_chk.sv
`timescale 1ns/1ps
module adc_pin_chk
  import adc_pin_pkg::*;
(
  input wire logic         hclk,
  input wire logic         hresetn,
  input wire logic         hreadyout,
  input wire logic         hresp,
  input wire logic         mclk_in,
  input wire logic         mclk_out,
  input wire logic         cs_n,
  input wire logic         dout_oe,
  input wire logic         data_ready_n,
  input wire logic         filter_sync_n,
  input wire logic         reset_pin_n,
  input wire logic         standby_n,
  input wire logic         buffer_sel,
  input wire analog_ctrl_s analog_ctrl
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ------------------------------------------------------------
  // Bus and clock pins
  // ------------------------------------------------------------
  chk_ahb_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_mclk_inverse: assert property (mclk_out == !mclk_in)
    else $error("master clock output not inverted");

  // ------------------------------------------------------------
  // Pin effects; five cycles cover the two-flop sync and register
  // ------------------------------------------------------------
  chk_sync_holds: assert property ((!filter_sync_n)[*5] |->
    analog_ctrl.filter_reset && analog_ctrl.modulator_reset)
    else $error("filter not held while sync low");
  chk_sync_release: assert property ($rose(filter_sync_n) &&
    reset_pin_n && standby_n |-> ##[1:6] !analog_ctrl.filter_reset)
    else $error("filter did not restart after sync");
  chk_standby_off: assert property ((!standby_n)[*5] |->
    analog_ctrl.shutdown)
    else $error("no shutdown in standby");
  chk_buffer_on: assert property ((buffer_sel && standby_n &&
    reset_pin_n)[*5] |-> analog_ctrl.buffer_en)
    else $error("buffer not in series");
  chk_buffer_off: assert property ((!buffer_sel)[*5] |->
    !analog_ctrl.buffer_en)
    else $error("buffer not bypassed");
  chk_cs_enable: assert property ((!cs_n && standby_n &&
    reset_pin_n)[*5] |-> dout_oe)
    else $error("data out not driven while selected");
  chk_cs_release: assert property (cs_n[*5] |-> !dout_oe)
    else $error("data out driven while deselected");
  chk_reset_pin: assert property ((!reset_pin_n)[*5] |->
    data_ready_n && analog_ctrl.filter_reset)
    else $error("reset pin did not restore idle state");
endmodule

bind adc_pin_control_logic adc_pin_chk chk
(
  .hclk, .hresetn, .hreadyout, .hresp, .mclk_in, .mclk_out, .cs_n,
  .dout_oe, .data_ready_n, .filter_sync_n, .reset_pin_n, .standby_n,
  .buffer_sel, .analog_ctrl
);

//--- test/serial_host.sv
`timescale 1ns/1ps
module serial_host
(
  output logic      sclk,
  output logic      din,
  output logic      cs_n,
  input  wire logic dout,
  input  wire logic idle_sel
);
  logic [23:0] rx_word = 24'h00_0000;

  // Clock parks at the idle level whenever no frame is open
  always @(idle_sel)
    if (cs_n) sclk = idle_sel;

  initial
  begin
    sclk = 1'b0;
    din = 1'b0;
    cs_n = 1'b1;
  end

  // One burst of n bits; count is kept by the device between bursts
  task automatic burst(input int n, input logic [23:0] tx);
    #13;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      din = tx[23-i];
      #160;
      sclk = !idle_sel;
      rx_word = {rx_word[22:0], dout};
      #160;
      sclk = idle_sel;
    end
    #160;
    cs_n = 1'b1;
    din = !din; // Released line shows no stale bit
  endtask
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb
  import adc_pin_pkg::*;
;
  logic         hclk = 1'b0;
  logic         hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]  haddr, hwdata, hrdata;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic         mclk_in = 1'b0;
  logic         mclk_out, sclk, din, cs_n, dout, data_ready_n;
  logic         idle_sel, filter_sync_n, reset_pin_n, standby_n;
  logic         buffer_sel;
  logic [3:0]   mdiv = 4'h0;
  analog_ctrl_s analog_ctrl;
  int           bad_count = 0;
  int           comparisons = 0;

  typedef struct packed
  {
    logic [2:0] code;
    logic       buf_on;
    logic [5:0] pos;
    logic [5:0] neg;
  } row_s;
  row_s rows [8] = '{
    '{3'h0, 1'b0, 6'h01, 6'h20}, '{3'h1, 1'b1, 6'h02, 6'h20},
    '{3'h2, 1'b0, 6'h04, 6'h20}, '{3'h3, 1'b1, 6'h08, 6'h20},
    '{3'h4, 1'b0, 6'h01, 6'h02}, '{3'h5, 1'b1, 6'h04, 6'h08},
    '{3'h6, 1'b0, 6'h10, 6'h20}, '{3'h7, 1'b1, 6'h00, 6'h00}};

  assign hready = hreadyout;
  always #20 hclk = !hclk;

  // Master clock at 1 MHz: 12 cycles high, 13 low, so 25 bus cycles
  always @(posedge hclk)
  begin
    if (mdiv == (mclk_in ? 4'hB : 4'hC))
    begin
      mdiv    <= 4'h0;
      mclk_in <= !mclk_in;
    end
    else
      mdiv <= mdiv + 4'h1;
  end

  adc_pin_control_logic uut
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .mclk_in, .mclk_out, .sclk,
    .din, .cs_n, .dout, .dout_oe (), .data_ready_n,
    .clock_idle_level_sel (idle_sel), .filter_sync_n, .reset_pin_n,
    .standby_n, .buffer_sel, .analog_ctrl
  );

  serial_host host
  (
    .sclk, .din, .cs_n, .dout, .idle_sel
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Single word transfer; waits on ready, takes data at the last edge
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // Bounded wait for the data ready pin to reach a level
  task automatic wait_ready(input logic lvl);
    int n;
    n = 0;
    while (data_ready_n !== lvl && n < 20000)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    check(32'(data_ready_n), 32'(lvl));
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [31:0] rd;
    int          n;
    {hresetn, hsel, hwrite, idle_sel, buffer_sel} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    {filter_sync_n, reset_pin_n, standby_n} = 3'h7;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, PERIOD_OFS, 32'h0000_0000, rd);
    check(rd, 32'h0000_07D0);
    ahb(1'b0, 8'h14, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    check(32'(data_ready_n), 32'h0000_0001);
    // Channel codes and buffer strap, one row each
    foreach (rows[i])
    begin
      buffer_sel <= rows[i].buf_on;
      ahb(1'b1, CTRL_OFS, 32'(rows[i].code), rd);
      repeat (6) @(posedge hclk);
      #1;
      check(32'(analog_ctrl.pos_sel), 32'(rows[i].pos));
      check(32'(analog_ctrl.neg_sel), 32'(rows[i].neg));
      check(32'(analog_ctrl.buffer_en), 32'(rows[i].buf_on));
      ahb(1'b0, CTRL_OFS, 32'h0000_0000, rd);
      check(32'(rd[2:0]), 32'(rows[i].code));
    end
    // Continuous frame, clock idling low
    ahb(1'b1, PERIOD_OFS, 32'h0000_0258, rd);
    ahb(1'b1, RESULT_OFS, 32'h00A5_C396, rd);
    wait_ready(1'b0);
    host.burst(24, 24'h3C_5AE1);
    check(32'(host.rx_word), 32'h00A5_C396);
    wait_ready(1'b1);
    ahb(1'b0, RX_OFS, 32'h0000_0000, rd);
    check(rd, 32'h0000_00E1);
    // Three bursts, clock idling high
    @(posedge hclk);
    idle_sel <= 1'b1;
    ahb(1'b1, RESULT_OFS, 32'h005A_3C69, rd);
    wait_ready(1'b0);
    for (int b = 0; b < 3; b++)
    begin
      host.burst(8, 24'h00_0000);
      repeat (10) @(posedge hclk);
    end
    check(32'(host.rx_word), 32'h005A_3C69);
    wait_ready(1'b1);
    // Sync while a word waits unread, then the early-high window
    wait_ready(1'b0);
    @(posedge hclk);
    filter_sync_n <= 1'b0;
    repeat (20) @(posedge hclk);
    #1;
    check(32'(data_ready_n), 32'h0000_0000);
    ahb(1'b0, STATUS_OFS, 32'h0000_0000, rd);
    check(32'(rd[ST_HELD]), 32'h0000_0001);
    filter_sync_n <= 1'b1;
    wait_ready(1'b1);
    n = 0;
    while (data_ready_n === 1'b1 && n < 15000)
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    check(32'(n > 12497 && n < 12503), 32'h0000_0001);
    // Reset pin while ready is low, then standby
    @(posedge hclk);
    reset_pin_n <= 1'b0;
    repeat (10) @(posedge hclk);
    #1;
    check(32'(data_ready_n), 32'h0000_0001);
    check(32'(analog_ctrl.filter_reset), 32'h0000_0001);
    @(posedge hclk);
    reset_pin_n <= 1'b1;
    standby_n <= 1'b0;
    repeat (10) @(posedge hclk);
    #1;
    check(32'(analog_ctrl.shutdown), 32'h0000_0001);
    @(posedge hclk);
    standby_n <= 1'b1;
    repeat (10) @(posedge hclk);
    end_of_test();
  end

  // Whole run needs about 60000 cycles at a 1 MHz master clock
  initial
  begin
    repeat (100000) @(posedge hclk);
    bad_count++;
    end_of_test();
  end
endmodule
